// >>> hw/sdcc_defines.svh
`ifndef SDCC_DEFINES_SVH
`define SDCC_DEFINES_SVH

`define SDCC_NUM_CHAN      8
`define SDCC_WORD_BITS     16
`define SDCC_CNT_FULL      5'h10

`define SDCC_BIT_MAIN_SUB  15
`define SDCC_BIT_KIND_LO   14
`define SDCC_BIT_KIND_HI   13
`define SDCC_BIT_SEL2      12
`define SDCC_BIT_SEL1      11
`define SDCC_BIT_SEL0      10

`define SDCC_BIT_REF_HI    9
`define SDCC_BIT_REF_LO    8
`define SDCC_BIT_ACTIVE    4
`define SDCC_BIT_ZEROING   3

`define SDCC_BIT_BINARY    6
`define SDCC_BIT_POWER     5
`define SDCC_BIT_SLEEP     4
`define SDCC_BIT_GZERO     3

`define SDCC_MAIN_HI       9
`define SDCC_MAIN_LO       0
`define SDCC_FINE_HI       9
`define SDCC_FINE_LO       2

`define SDCC_RST_POWER     1'b1
`define SDCC_RST_SLEEP     1'b1
`define SDCC_RST_BINARY    1'b0
`define SDCC_RST_GZERO     1'b0
`define SDCC_RST_ACTIVE    1'b1
`define SDCC_RST_ZEROING   1'b1
`define SDCC_RST_REF       2'h0
`define SDCC_RST_MAIN      10'h000
`define SDCC_RST_FINE      8'h00

`define SDCC_CLR_TWOS      10'h000
`define SDCC_CLR_OFFSET    10'h000

`endif

// >>> hw/sdcc_pkg.sv
`include "sdcc_defines.svh"

package sdcc_pkg;

  localparam int NCH = `SDCC_NUM_CHAN;

  typedef enum logic [1:0] {
    SDCC_KIND_GLOBAL,
    SDCC_KIND_CHAN,
    SDCC_KIND_DATA
  } sdcc_kind_e;

  typedef logic [NCH-1:0][9:0] sdcc_main_t;
  typedef logic [NCH-1:0][7:0] sdcc_fine_t;
  typedef logic [NCH-1:0][1:0] sdcc_ref_t;

  typedef struct packed {
    logic [15:0] sh;
    logic [4:0]  cnt;
    logic        done;
  } sdcc_link_s;

  typedef struct packed {
    logic [1:0]     done_sync;
    logic           done_prev;
    logic [1:0]     load_sync;
    logic           load_prev;
    logic           power_keep_n;
    logic           global_sleep;
    logic           coding_offset_binary;
    logic           global_zeroing;
    logic [NCH-1:0] channel_active;
    logic [NCH-1:0] channel_zeroing;
    sdcc_ref_t      ref_pick;
    sdcc_main_t     main_data;
    sdcc_main_t     main_dac;
    sdcc_fine_t     fine_data;
    sdcc_fine_t     fine_dac;
    logic [NCH-1:0] powered;
    logic           word_strobe;
  } sdcc_sys_s;

endpackage

// >>> hw/sdcc_top.sv
// Overview of operation
// - channel picked by three select bits; quad variant ignores the top bit.
// - channel active bit zero puts only the addressed channel in low power.
// - channel active bit one returns the addressed channel to operation.
// - channel zeroing one clears the main data; zero means normal operation.
// - channel zeroing touches only main data; fine data is kept.
// - channel zeroing change acts only on the next load strobe.
// - zeroing code is midscale for twos complement, bottom for offset binary.
// - two-bit reference pick per channel selects the bias source.
// - data word top bit one writes fine data, zero writes main data.
// - fine data is eight bits; word bits one and zero are ignored.
// - fine code follows the global coding choice.
// - after reset power kept and global sleep both read one.
// - after reset each channel: active one, zeroing one, reference 00.
// - host finally writes data: kind, address, then ten data bits.
// - while frame low, data shifts in msb first on falling link edges.
// - word bits 13 and 14 select global, channel or data registers.
// - load strobe going low copies data registers to dac registers; zeroing channels get the clear code instead.
// - power kept bit zero shuts reference and dacs, registers retained.
`timescale 1ns/1ps
`default_nettype none

module sdcc_top
  import sdcc_pkg::*;
#(
  parameter bit OCTAL = 1'b1
) (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        serial_shift_clock_i,
  input  wire logic        frame_sync_n_i,
  input  wire logic        serial_in_i,
  input  wire logic        output_load_n_i,
  output logic             reference_on_o,
  output logic             coding_offset_binary_o,
  output logic [sdcc_pkg::NCH-1:0] channel_powered_o,
  output sdcc_pkg::sdcc_ref_t      ref_pick_o,
  output sdcc_pkg::sdcc_main_t     main_dac_o,
  output sdcc_pkg::sdcc_fine_t     fine_dac_o,
  output logic             word_strobe_o
);

  import sdcc_pkg::*;

  sdcc_link_s link_q;
  sdcc_link_s link_d;
  sdcc_sys_s  sys_q;
  sdcc_sys_s  sys_d;

  logic [15:0] word;
  logic [NCH-1:0] hit;
  sdcc_kind_e  kind;
  logic        word_new;
  logic        load_fall;
  logic [9:0]  clear_code;

  // one-hot channel decode from the select field
  function automatic logic [NCH-1:0] chan_sel(
    input logic [15:0] w,
    input bit          octal
  );
    logic [2:0] idx;
    idx = {w[`SDCC_BIT_SEL2] & octal,
           w[`SDCC_BIT_SEL1],
           w[`SDCC_BIT_SEL0]};
    chan_sel = '0;
    chan_sel[idx] = 1'b1;
  endfunction

  // register group picked by the two kind bits
  function automatic sdcc_kind_e word_kind(
    input logic [15:0] w
  );
    if (w[`SDCC_BIT_KIND_HI]) begin
      word_kind = SDCC_KIND_DATA;
    end else if (w[`SDCC_BIT_KIND_LO]) begin
      word_kind = SDCC_KIND_CHAN;
    end else begin
      word_kind = SDCC_KIND_GLOBAL;
    end
  endfunction

  // link side: shift in on falling edges, frame high clears
  always_comb begin
    link_d = link_q;
    if (!link_q.done) begin
      link_d.sh  = {link_q.sh[14:0], serial_in_i};
      link_d.cnt = link_q.cnt + 5'h01;
      if (link_d.cnt == `SDCC_CNT_FULL) begin
        link_d.done = 1'b1;
      end
    end
  end

  // extra edges after a full word are ignored until the frame ends
  always_ff @(negedge serial_shift_clock_i or posedge frame_sync_n_i) begin
    if (frame_sync_n_i) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // system side decode helpers
  assign word      = link_q.sh;
  assign hit       = chan_sel(word, OCTAL);
  assign kind      = word_kind(word);
  assign word_new  = sys_q.done_sync[1] & ~sys_q.done_prev;
  assign load_fall = sys_q.load_prev & ~sys_q.load_sync[1];

  always_comb begin
    if (sys_q.coding_offset_binary) begin
      clear_code = `SDCC_CLR_OFFSET;
    end else begin
      clear_code = `SDCC_CLR_TWOS;
    end
  end

  always_comb begin
    sys_d = sys_q;
    sys_d.done_sync = {sys_q.done_sync[0], link_q.done};
    sys_d.done_prev = sys_q.done_sync[1];
    sys_d.load_sync = {sys_q.load_sync[0], output_load_n_i};
    sys_d.load_prev = sys_q.load_sync[1];
    sys_d.word_strobe = word_new;

    if (word_new) begin
      case (kind)
        SDCC_KIND_GLOBAL: begin
          sys_d.coding_offset_binary = word[`SDCC_BIT_BINARY];
          sys_d.power_keep_n = word[`SDCC_BIT_POWER];
          sys_d.global_sleep = word[`SDCC_BIT_SLEEP];
          sys_d.global_zeroing = word[`SDCC_BIT_GZERO];
        end
        SDCC_KIND_CHAN: begin
          for (int i = 0; i < NCH; i++) begin
            if (hit[i]) begin
              sys_d.channel_active[i] =
                word[`SDCC_BIT_ACTIVE];
              sys_d.channel_zeroing[i] =
                word[`SDCC_BIT_ZEROING];
              sys_d.ref_pick[i] =
                word[`SDCC_BIT_REF_HI:`SDCC_BIT_REF_LO];
            end
          end
        end
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (hit[i]) begin
              if (word[`SDCC_BIT_MAIN_SUB]) begin
                sys_d.fine_data[i] =
                  word[`SDCC_FINE_HI:`SDCC_FINE_LO];
              end else begin
                sys_d.main_data[i] =
                  word[`SDCC_MAIN_HI:`SDCC_MAIN_LO];
              end
            end
          end
        end
      endcase
    end

    // zeroing is applied only at the load strobe
    if (load_fall) begin
      for (int i = 0; i < NCH; i++) begin
        if (sys_q.channel_zeroing[i] | sys_q.global_zeroing) begin
          sys_d.main_data[i] = clear_code;
          sys_d.main_dac[i]  = clear_code;
        end else begin
          sys_d.main_dac[i]  = sys_d.main_data[i];
        end
        sys_d.fine_dac[i] = sys_d.fine_data[i];
      end
    end

    for (int i = 0; i < NCH; i++) begin
      sys_d.powered[i] = sys_d.channel_active[i]
                         & ~sys_d.global_sleep
                         & sys_d.power_keep_n;
      if (!OCTAL && i >= 4) begin
        sys_d.powered[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      sys_q <= '0;
      sys_q.load_sync <= 2'h3;
      sys_q.load_prev <= 1'b1;
      sys_q.power_keep_n <= `SDCC_RST_POWER;
      sys_q.global_sleep <= `SDCC_RST_SLEEP;
      sys_q.coding_offset_binary <= `SDCC_RST_BINARY;
      sys_q.global_zeroing <= `SDCC_RST_GZERO;
      sys_q.channel_active <= {NCH{`SDCC_RST_ACTIVE}};
      sys_q.channel_zeroing <= {NCH{`SDCC_RST_ZEROING}};
      sys_q.ref_pick <= {NCH{`SDCC_RST_REF}};
      sys_q.main_data <= {NCH{`SDCC_RST_MAIN}};
      sys_q.main_dac <= {NCH{`SDCC_RST_MAIN}};
      sys_q.fine_data <= {NCH{`SDCC_RST_FINE}};
      sys_q.fine_dac <= {NCH{`SDCC_RST_FINE}};
    end else begin
      sys_q <= sys_d;
    end
  end

  assign reference_on_o         = sys_q.power_keep_n;
  assign coding_offset_binary_o = sys_q.coding_offset_binary;
  assign channel_powered_o      = sys_q.powered;
  assign ref_pick_o             = sys_q.ref_pick;
  assign main_dac_o             = sys_q.main_dac;
  assign fine_dac_o             = sys_q.fine_dac;
  assign word_strobe_o          = sys_q.word_strobe;

endmodule

`default_nettype wire

// >>> dv/sdcc_props.sv
`timescale 1ns/1ps
`default_nettype none

module sdcc_props
  import sdcc_pkg::*;
(
  input wire logic                 sys_clk_i,
  input wire logic                 resetn_i,
  input wire logic                 output_load_n_i,
  input wire logic                 reference_on_o,
  input wire logic                 coding_offset_binary_o,
  input wire logic [sdcc_pkg::NCH-1:0] channel_powered_o,
  input wire sdcc_pkg::sdcc_ref_t  ref_pick_o,
  input wire sdcc_pkg::sdcc_main_t main_dac_o,
  input wire sdcc_pkg::sdcc_fine_t fine_dac_o,
  input wire logic                 word_strobe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  reset_vals_a: assert property (disable iff (1'b0)
    !resetn_i |=> reference_on_o &&
    channel_powered_o == '0 && ref_pick_o == '0)
    else $error("reset values wrong");
  strobe_pulse_a: assert property (word_strobe_o |=> !word_strobe_o)
    else $error("word strobe longer than one cycle");
  coding_word_a: assert property ($changed(coding_offset_binary_o)
    |-> word_strobe_o) else $error("coding changed without a word");
  ref_word_a: assert property ($changed(ref_pick_o) |-> word_strobe_o)
    else $error("reference pick changed without a word");
  main_load_a: assert property ($changed(main_dac_o) |->
    !$past(output_load_n_i, 3) && $past(output_load_n_i, 4))
    else $error("main dac changed without a load");
  fine_load_a: assert property ($changed(fine_dac_o) |->
    !$past(output_load_n_i, 3) && $past(output_load_n_i, 4))
    else $error("fine dac changed without a load");
  power_gate_a: assert property (!reference_on_o |->
    channel_powered_o == '0) else $error("channel powered in power down");
  load_held_a: assert property (!output_load_n_i [*5] |=>
    $stable(main_dac_o)) else $error("held load changed main dac");

  cover property (word_strobe_o);
  cover property ($fell(output_load_n_i));
  cover property (coding_offset_binary_o && !reference_on_o);
endmodule

bind sdcc_top sdcc_props u_props (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .output_load_n_i(output_load_n_i), .reference_on_o(reference_on_o),
  .coding_offset_binary_o(coding_offset_binary_o),
  .channel_powered_o(channel_powered_o), .ref_pick_o(ref_pick_o),
  .main_dac_o(main_dac_o), .fine_dac_o(fine_dac_o),
  .word_strobe_o(word_strobe_o));

`default_nettype wire

// >>> dv/sdcc_host.sv
`timescale 1ns/1ps
`default_nettype none

module sdcc_host (
  output logic sclk_o,
  output logic fsn_o,
  output logic sdi_o
);
  initial begin
    sclk_o = 1'b1;
    sdi_o = 1'b0;
    fsn_o = 1'b0;
    // rising frame clears the link shifter, which has no other reset
    #1 fsn_o = 1'b1;
  end

  task automatic send(input logic [15:0] w);
    fsn_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi_o = w[i];
      #62.5 sclk_o = 1'b0;
      #62.5 sclk_o = 1'b1;
    end
    #100 fsn_o = 1'b1;
    sdi_o = ~sdi_o;
    #100;
  endtask
endmodule

`default_nettype wire

// >>> dv/sdcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sdcc_top_tb;
  import sdcc_pkg::*;
  logic clk = 0, rstn = 0, ld_n = 1, ref_on, cob, strb;
  wire logic sclk, fsn, sdi;
  logic [NCH-1:0] pw;
  sdcc_ref_t rp;
  sdcc_main_t md;
  sdcc_fine_t fd;
  int errors = 0, n_checks = 0;

  sdcc_host host (.sclk_o(sclk), .fsn_o(fsn), .sdi_o(sdi));
  sdcc_top uut (.sys_clk_i(clk), .resetn_i(rstn),
    .serial_shift_clock_i(sclk), .frame_sync_n_i(fsn),
    .serial_in_i(sdi), .output_load_n_i(ld_n), .reference_on_o(ref_on),
    .coding_offset_binary_o(cob), .channel_powered_o(pw),
    .ref_pick_o(rp), .main_dac_o(md), .fine_dac_o(fd),
    .word_strobe_o(strb));

  initial forever #5 clk = ~clk;

  task automatic ck(string n, logic [15:0] e, logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(logic [15:0] w);
    host.send(w);
    repeat (3) @(posedge clk);
  endtask

  task automatic load();
    @(posedge clk) ld_n <= 1'b0;
    repeat (5) @(posedge clk);
    ld_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_setup();
    wr(16'h0060);
    ck("coding", 1, cob);
    for (int c = 0; c < 8; c++) begin
      wr(16'h4010 | (c << 10) | ((c % 4) << 8));
      ck("ref", c % 4, rp[c]);
    end
    ck("powered", 8'hff, pw);
  endtask

  task automatic t_data();
    wr(16'h3691);
    wr(16'hb7ff);
    ck("main pre", 0, md[5]);
    load();
    ck("main", 10'h291, md[5]);
    ck("fine", 8'hff, fd[5]);
    ck("main other", 0, md[4]);
  endtask

  task automatic t_clear();
    wr(16'h5418);
    ck("main held", 10'h291, md[5]);
    load();
    ck("main clr", 10'h000, md[5]);
    ck("fine kept", 8'hff, fd[5]);
  endtask

  task automatic t_standby();
    wr(16'h4800);
    ck("pw off2", 8'hfb, pw);
    wr(16'h4810);
    ck("pw on2", 8'hff, pw);
    wr(16'h0040);
    ck("ref off", 0, ref_on);
    ck("pw down", 0, pw);
    wr(16'h0060);
    ck("pw back", 8'hff, pw);
  endtask

  task automatic t_sysclr();
    wr(16'h2155);
    wr(16'h0068);
    load();
    ck("main gclr", 10'h000, md[0]);
    ck("fine gkept", 8'hff, fd[5]);
    wr(16'h0060);
    wr(16'h2155);
    load();
    ck("main gback", 10'h155, md[0]);
  endtask

  task automatic close_out();
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    ck("ref on", 1, ref_on);
    ck("pw rst", 0, pw);
    ck("ref rst", 0, rp[0]);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_setup();
    t_data();
    t_clear();
    t_standby();
    t_sysclr();
    close_out();
  end
endmodule

`default_nettype wire
